// file: hw/csub_pkg.sv
/*
 * Shared constants for the channel status and user data buffer map:
 * page codes, buffer offsets, frame counts and the status CRC.
 * Assumes byte-wide host access with a seven-bit register offset.
 */
package csub_pkg;

   localparam int         CSUB_OFF_W      = 7;
   localparam int         CSUB_IDX_W      = 5;
   localparam logic [6:0] CSUB_CS_LAST    = 7'h2f;
   localparam logic [6:0] CSUB_UD_BASE    = 7'h40;
   localparam logic [6:0] CSUB_UD_LAST    = 7'h6f;
   localparam logic [6:0] CSUB_PAGE_ADDR  = 7'h7f;

   localparam logic [1:0] CSUB_PG_CTRL    = 2'h0;
   localparam logic [1:0] CSUB_PG_RX      = 2'h1;
   localparam logic [1:0] CSUB_PG_TX      = 2'h2;
   localparam logic [1:0] CSUB_PG_RSVD    = 2'h3;

   localparam logic [4:0] CSUB_CRC_BYTE   = 5'h17;
   localparam logic [7:0] CSUB_CRC_INIT   = 8'hff;
   localparam logic [7:0] CSUB_CRC_POLY   = 8'h1d;
   localparam logic [7:0] CSUB_LAST_FRAME = 8'hbf;
   localparam logic [2:0] CSUB_BIT_LAST   = 3'h7;
   localparam int         CSUB_MODE_BIT   = 7;

   localparam logic [1:0] CSUB_SRC_ZERO   = 2'h0;
   localparam logic [1:0] CSUB_SRC_RX     = 2'h1;
   localparam logic [1:0] CSUB_SRC_TX     = 2'h2;
   localparam logic [1:0] CSUB_SRC_CONST  = 2'h3;

   // Bytes are stored with the first stream bit in the MSB, so the
   // serial CRC walks each stored byte from bit 7 down to bit 0.
   function automatic logic [7:0] csub_crc_fold(input logic [7:0] crc,
                                                input logic [7:0] b);
      logic [7:0] c;
      c = crc;
      for (int i = 7; i >= 0; i--) begin
         if (c[7] ^ b[i]) begin
            c = {c[6:0], 1'b0} ^ CSUB_CRC_POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      return c;
   endfunction

endpackage

// file: hw/csub_mem.sv
/*
 * Byte memory with one write port and two registered read ports.
 * Assumes a single clock; contents are not cleared by reset.
 */
`timescale 1ns/1ps
module csub_mem #(
   parameter int W     = 8,
   parameter int AW    = 8,
   parameter int DEPTH = 256
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [W-1:0]  wr_data,
   input  wire logic [AW-1:0] rd_a_addr,
   output logic      [W-1:0]  rd_a_data,
   input  wire logic [AW-1:0] rd_b_addr,
   output logic      [W-1:0]  rd_b_data
);

   if (DEPTH > (1 << AW) || W < 1) begin : g_chk
      $error("csub_mem: depth does not fit the address width");
   end

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [W-1:0]            qa;
      logic [W-1:0]            qb;
   } csub_mem_state_t;

   csub_mem_state_t s;
   csub_mem_state_t next_s;

   always_comb begin
      next_s    = s;
      next_s.qa = s.mem[rd_a_addr];
      next_s.qb = s.mem[rd_b_addr];
      if (wr_en) begin
         next_s.mem[wr_addr] = wr_data;
      end
   end

   // Only the read registers are cleared; clearing the array would
   // cost a wide reset tree for no behavioural gain.
   always_ff @(posedge clk) begin
      s <= next_s;
      if (rst) begin
         s.qa <= '0;
         s.qb <= '0;
      end
   end

   assign rd_a_data = s.qa;
   assign rd_b_data = s.qb;

endmodule

// file: hw/csub_buf.sv
/*
 * Paged channel status and user data buffers for a digital audio
 * receiver and transmitter, with mode tracking and status CRC.
 * Assumes a serial host port decoder outside that presents byte
 * accesses here, a receiver that delivers one status and one user
 * bit per subframe, and a transmitter that fetches status bytes.
 */
`timescale 1ns/1ps
// Notes on behaviour
// - Status byte 0 first bit selects mode: 0 consumer, 1 professional.
// - Status byte meaning, CRC check and CRC insertion follow that mode.
// - Professional transmitter sends its own CRC as status byte 23.
// - Receiver status bytes at page-1 offsets 0-2F, byte n at 2n+ch.
// - Receiver user bytes at page-1 offsets 40-6F, interleaved channels.
// - First stream bit of each byte is stored in the MSB.
// - Page selector at 7F on every page: ctrl, rx, tx, reserved.
module csub_buf (
   input  wire logic                             clk,
   input  wire logic                             rst,
   input  wire logic                             host_req,
   input  wire logic                             host_we,
   input  wire logic [csub_pkg::CSUB_OFF_W-1:0]  host_addr,
   input  wire logic [7:0]                       host_wdata,
   output logic                                  host_ack,
   output logic      [7:0]                       host_rdata,
   output logic      [1:0]                       page,
   input  wire logic                             rx_valid,
   input  wire logic                             rx_chan,
   input  wire logic                             rx_block_start,
   input  wire logic                             rx_cs_bit,
   input  wire logic                             rx_ud_bit,
   output logic                                  rx_pro_mode,
   output logic      [1:0]                       rx_crc_err,
   input  wire logic                             tx_req,
   input  wire logic                             tx_ud,
   input  wire logic                             tx_chan,
   input  wire logic [csub_pkg::CSUB_IDX_W-1:0]  tx_byte_idx,
   output logic                                  tx_ack,
   output logic      [7:0]                       tx_byte
);
   import csub_pkg::*;

   typedef struct packed {
      logic [1:0]      page;
      logic            bank;
      logic [7:0]      frame;
      logic [1:0][7:0] cs_sh;
      logic [1:0][7:0] ud_sh;
      logic            ud_pend;
      logic [6:0]      ud_off;
      logic [7:0]      ud_data;
      logic            commit_pend;
      logic [1:0][7:0] rx_crc;
      logic [1:0]      rx_pro;
      logic [1:0]      rx_bad;
      logic [1:0]      rx_first;
      logic            pro_mode;
      logic [1:0]      crc_err;
      logic            h_s1;
      logic [1:0]      h_src;
      logic [7:0]      h_const;
      logic            host_ack;
      logic [7:0]      host_rdata;
      logic            t_s1;
      logic            t_ud;
      logic            t_ch;
      logic [4:0]      t_idx;
      logic [1:0][7:0] tx_crc;
      logic [1:0]      tx_pro;
      logic            tx_ack;
      logic [7:0]      tx_byte;
   } csub_state_t;

   csub_state_t s;
   csub_state_t next_s;

   logic [7:0] fe;
   logic [4:0] bi;
   logic [7:0] cs_byte;
   logic [7:0] ud_byte;
   logic       cs_done;
   logic       rx_we;
   logic [7:0] rx_waddr;
   logic [7:0] rx_wdata;
   logic [7:0] rx_rd;
   logic [7:0] tx_rd_host;
   logic [7:0] tx_rd_link;
   logic       in_buf;
   logic       tx_we;

   // A block start restarts the frame count; a half-filled bank is
   // simply overwritten because it is never swapped in.
   assign fe      = rx_block_start ? '0 : s.frame;
   assign bi      = fe[7:3];
   assign cs_byte = {s.cs_sh[rx_chan][6:0], rx_cs_bit};
   assign ud_byte = {s.ud_sh[rx_chan][6:0], rx_ud_bit};
   assign cs_done = rx_valid && (fe[2:0] == CSUB_BIT_LAST);
   // The user byte is written one cycle after its status byte, which
   // is why subframes must be at least two cycles apart.
   assign rx_we    = cs_done || s.ud_pend;
   assign rx_waddr = cs_done ? {s.bank, 1'b0, bi, rx_chan}
                             : {s.bank, s.ud_off};
   assign rx_wdata = cs_done ? cs_byte : s.ud_data;

   assign in_buf = (host_addr <= CSUB_CS_LAST) ||
                   (host_addr >= CSUB_UD_BASE && host_addr <= CSUB_UD_LAST);
   assign tx_we  = host_req && host_we && (s.page == CSUB_PG_TX) && in_buf;

   // Host reads always see the committed bank, never the one filling.
   csub_mem #(.W(8), .AW(8), .DEPTH(256)) u_rx_mem (
      .clk       (clk),
      .rst       (rst),
      .wr_en     (rx_we),
      .wr_addr   (rx_waddr),
      .wr_data   (rx_wdata),
      .rd_a_addr ({~s.bank, host_addr}),
      .rd_a_data (rx_rd),
      .rd_b_addr (rx_waddr),
      .rd_b_data ()
   );

   csub_mem #(.W(8), .AW(7), .DEPTH(128)) u_tx_mem (
      .clk       (clk),
      .rst       (rst),
      .wr_en     (tx_we),
      .wr_addr   (host_addr),
      .wr_data   (host_wdata),
      .rd_a_addr (host_addr),
      .rd_a_data (tx_rd_host),
      .rd_b_addr ({tx_ud, tx_byte_idx, tx_chan}),
      .rd_b_data (tx_rd_link)
   );

   always_comb begin
      next_s = s;
      // Host access: offset 7F selects the page on every page.
      next_s.host_ack = s.h_s1;
      next_s.h_s1     = host_req;
      next_s.h_src    = CSUB_SRC_ZERO;
      next_s.h_const  = '0;
      if (host_req) begin
         if (host_addr == CSUB_PAGE_ADDR) begin
            next_s.h_src   = CSUB_SRC_CONST;
            next_s.h_const = {6'h00, s.page};
            if (host_we) begin
               next_s.page = host_wdata[1:0];
            end
         end else if (in_buf && !host_we && s.page == CSUB_PG_RX) begin
            next_s.h_src = CSUB_SRC_RX;
         end else if (in_buf && !host_we && s.page == CSUB_PG_TX) begin
            next_s.h_src = CSUB_SRC_TX;
         end
      end
      if (s.h_s1) begin
         case (s.h_src)
            CSUB_SRC_RX:    next_s.host_rdata = rx_rd;
            CSUB_SRC_TX:    next_s.host_rdata = tx_rd_host;
            CSUB_SRC_CONST: next_s.host_rdata = s.h_const;
            default:        next_s.host_rdata = '0;
         endcase
      end

      // Receiver capture into the filling bank.
      next_s.ud_pend     = cs_done;
      next_s.commit_pend = 1'b0;
      if (rx_valid) begin
         next_s.cs_sh[rx_chan] = cs_byte;
         next_s.ud_sh[rx_chan] = ud_byte;
         if (fe[2:0] == '0) begin
            next_s.rx_first[rx_chan] = rx_cs_bit;
         end
         if (cs_done) begin
            next_s.ud_off  = CSUB_UD_BASE | {1'b0, bi, rx_chan};
            next_s.ud_data = ud_byte;
            if (bi == '0) begin
               next_s.rx_crc[rx_chan] = csub_crc_fold(CSUB_CRC_INIT, cs_byte);
               next_s.rx_pro[rx_chan] = cs_byte[CSUB_MODE_BIT];
               next_s.rx_bad[rx_chan] = 1'b0;
            end else if (bi < CSUB_CRC_BYTE) begin
               next_s.rx_crc[rx_chan] =
                  csub_crc_fold(s.rx_crc[rx_chan], cs_byte);
            end else begin
               // Only professional blocks carry a CRC to check.
               next_s.rx_bad[rx_chan] = s.rx_pro[rx_chan] &&
                  (cs_byte != s.rx_crc[rx_chan]);
            end
         end
         if (rx_chan) begin
            next_s.frame = (fe == CSUB_LAST_FRAME) ? '0 : fe + 8'h01;
            next_s.commit_pend = (fe == CSUB_LAST_FRAME);
         end else begin
            next_s.frame = fe;
         end
      end
      if (s.commit_pend) begin
         next_s.bank     = ~s.bank;
         next_s.pro_mode = s.rx_pro[0];
         next_s.crc_err  = s.rx_bad;
      end

      // Transmitter fetch; bytes of a channel are fetched in order.
      next_s.tx_ack = s.t_s1;
      next_s.t_s1   = tx_req;
      next_s.t_ud   = tx_ud;
      next_s.t_ch   = tx_chan;
      next_s.t_idx  = tx_byte_idx;
      if (s.t_s1) begin
         next_s.tx_byte = (s.t_idx <= CSUB_CRC_BYTE) ? tx_rd_link : '0;
         if (!s.t_ud) begin
            if (s.t_idx == '0) begin
               next_s.tx_crc[s.t_ch] = csub_crc_fold(CSUB_CRC_INIT,
                                                     tx_rd_link);
               next_s.tx_pro[s.t_ch] = tx_rd_link[CSUB_MODE_BIT];
            end else if (s.t_idx < CSUB_CRC_BYTE) begin
               next_s.tx_crc[s.t_ch] = csub_crc_fold(s.tx_crc[s.t_ch],
                                                     tx_rd_link);
            end else if (s.t_idx == CSUB_CRC_BYTE && s.tx_pro[s.t_ch]) begin
               // Host content of byte 23 is never used here.
               next_s.tx_byte = s.tx_crc[s.t_ch];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign host_ack    = s.host_ack;
   assign host_rdata  = s.host_rdata;
   assign page        = s.page;
   assign rx_pro_mode = s.pro_mode;
   assign rx_crc_err  = s.crc_err;
   assign tx_ack      = s.tx_ack;
   assign tx_byte     = s.tx_byte;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_page_write: assert property (
      host_req && host_we && host_addr == CSUB_PAGE_ADDR
      |=> page == $past(host_wdata[1:0]))
      else $error("page selector did not take the written value");
   a_page_readback: assert property (
      host_req && !host_we && host_addr == CSUB_PAGE_ADDR
      |-> ##2 host_ack && host_rdata == {6'h00, $past(s.page, 2)})
      else $error("page selector read back wrong");
   a_host_latency: assert property (
      host_ack == $past(host_req, 2))
      else $error("host answer not two cycles after request");
   a_bank_swap: assert property (
      rx_valid && rx_chan && fe == CSUB_LAST_FRAME
      |=> s.commit_pend ##1 s.bank != $past(s.bank, 2))
      else $error("bank not swapped after last frame");
   a_bank_stable: assert property (
      $changed(s.bank) |-> $past(s.commit_pend))
      else $error("bank changed outside a block boundary");
   a_mode_commit: assert property (
      s.commit_pend |=> rx_pro_mode == $past(s.rx_pro[0]))
      else $error("mode output does not follow status byte 0");
   a_msb_first: assert property (
      cs_done |-> rx_wdata[7] == s.rx_first[rx_chan])
      else $error("first stream bit not in byte MSB");
   a_cs_offset: assert property (
      cs_done |-> rx_waddr[6:0] <= CSUB_CS_LAST && rx_waddr[0] == rx_chan)
      else $error("status byte at wrong offset");
   a_ud_offset: assert property (
      s.ud_pend |-> rx_waddr[6:0] >= CSUB_UD_BASE &&
                    rx_waddr[6:0] <= CSUB_UD_LAST)
      else $error("user byte at wrong offset");
   a_tx_crc_sub: assert property (
      tx_req && !tx_ud && tx_byte_idx == CSUB_CRC_BYTE
      && s.tx_pro[tx_chan] && !s.t_s1
      |=> ##1 tx_ack && tx_byte == $past(s.tx_crc[s.t_ch]))
      else $error("professional byte 23 is not the computed CRC");
   a_tx_consumer: assert property (
      tx_req && !tx_ud && tx_byte_idx == CSUB_CRC_BYTE
      && !s.tx_pro[tx_chan] && !s.t_s1
      |=> ##1 tx_byte == $past(tx_rd_link))
      else $error("consumer byte 23 not passed from the buffer");

   c_commit:   cover property (s.commit_pend && !s.crc_err[0]);
   c_crc_sub:  cover property (s.t_s1 && s.t_idx == CSUB_CRC_BYTE &&
                               s.tx_pro[s.t_ch]);
   c_tx_write: cover property (tx_we);
   c_rx_read:  cover property (s.h_s1 && s.h_src == CSUB_SRC_RX);

endmodule

// file: tb/csub_host_model.sv
/*
 * Host processor model for the buffer map: single byte accesses on
 * the host port and page selection.
 * Assumes one calling process and the two-cycle answer of the port.
 */
`timescale 1ns/1ps
module csub_host_model (
   input  wire logic       clk,
   output logic            host_req,
   output logic            host_we,
   output logic      [6:0] host_addr,
   output logic      [7:0] host_wdata,
   input  wire logic       host_ack,
   input  wire logic [7:0] host_rdata,
   output logic            timed_out
);
   initial begin
      host_req   = 1'b0;
      host_we    = 1'b0;
      host_addr  = 7'h00;
      host_wdata = 8'h00;
      timed_out  = 1'b0;
   end

   // Offset and data are inverted after the taking edge, so a design
   // that samples them late picks up garbage rather than a lucky match.
   task automatic access(input logic we, input logic [6:0] a,
                         input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clk);
      host_req   <= 1'b1;
      host_we    <= we;
      host_addr  <= a;
      host_wdata <= d;
      @(posedge clk);
      host_req   <= 1'b0;
      host_we    <= ~we;
      host_addr  <= ~a;
      host_wdata <= ~d;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (host_ack !== 1'b1 && n < 8);
      if (n >= 8) begin
         timed_out = 1'b1;
      end
      q = host_rdata;
   endtask

   task automatic set_page(input logic [1:0] p);
      logic [7:0] q;
      access(1'b1, 7'h7f, {6'h00, p}, q);
   endtask
endmodule

// file: tb/csub_buf_bench.sv
/*
 * Self-checking bench for the channel status and user data buffers:
 * receiver blocks in, host reads, transmitter fetches with CRC.
 * Assumes the host model beside it and a 100 MHz clock.
 */
`timescale 1ns/1ps
module csub_buf_bench;
   import csub_pkg::*;
   logic clk = 1'b0, rst = 1'b1;
   logic rx_valid = 1'b0, rx_chan = 1'b0, rx_block_start = 1'b0;
   logic rx_cs_bit = 1'b0, rx_ud_bit = 1'b0;
   logic tx_req = 1'b0, tx_ud = 1'b0, tx_chan = 1'b0;
   logic [4:0] tx_byte_idx = 5'h00;
   logic host_req, host_we, host_ack, rx_pro_mode, tx_ack, to;
   logic [6:0] host_addr;
   logic [7:0] host_wdata, host_rdata, tx_byte, q;
   logic [1:0] page, rx_crc_err;
   logic [7:0] cs [2][24];
   logic [7:0] ud [2][24];
   int failures = 0;
   int tests_run = 0;
   int seed, a;

   always #5 clk = ~clk;

   csub_host_model u_host (.clk(clk), .host_req(host_req),
      .host_we(host_we), .host_addr(host_addr), .host_wdata(host_wdata),
      .host_ack(host_ack), .host_rdata(host_rdata), .timed_out(to));

   csub_buf u_dut (.clk(clk), .rst(rst), .host_req(host_req),
      .host_we(host_we), .host_addr(host_addr), .host_wdata(host_wdata),
      .host_ack(host_ack), .host_rdata(host_rdata), .page(page),
      .rx_valid(rx_valid), .rx_chan(rx_chan),
      .rx_block_start(rx_block_start), .rx_cs_bit(rx_cs_bit),
      .rx_ud_bit(rx_ud_bit), .rx_pro_mode(rx_pro_mode),
      .rx_crc_err(rx_crc_err), .tx_req(tx_req), .tx_ud(tx_ud),
      .tx_chan(tx_chan), .tx_byte_idx(tx_byte_idx), .tx_ack(tx_ack),
      .tx_byte(tx_byte));

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Bit-serial reference over the 184 stream bits ahead of byte 23.
   function automatic logic [7:0] crc_ref(input int ch);
      logic [7:0] c;
      logic       fb;
      c = CSUB_CRC_INIT;
      for (int i = 0; i < 184; i++) begin
         fb = c[7] ^ cs[ch][i/8][7-i%8];
         c = {c[6:0], 1'b0} ^ (fb ? CSUB_CRC_POLY : 8'h00);
      end
      return c;
   endfunction

   task automatic gen_block(input logic pro);
      for (int ch = 0; ch < 2; ch++) begin
         for (int b = 0; b < 24; b++) begin
            cs[ch][b] = 8'($urandom);
            ud[ch][b] = 8'($urandom);
         end
         cs[ch][0][7] = pro;
      end
   endtask

   // An inverted partial block checks that unfinished blocks stay hidden.
   task automatic send_block(input int nf, input logic inv);
      for (int f = 0; f < nf; f++) begin
         for (int ch = 0; ch < 2; ch++) begin
            @(posedge clk);
            rx_valid       <= 1'b1;
            rx_block_start <= (f == 0 && ch == 0);
            rx_chan        <= 1'(ch);
            rx_cs_bit      <= cs[ch][f/8][7-f%8] ^ inv;
            rx_ud_bit      <= ud[ch][f/8][7-f%8] ^ inv;
            @(posedge clk);
            rx_valid       <= 1'b0;
            rx_block_start <= 1'b0;
            rx_cs_bit      <= ~cs[ch][f/8][7-f%8];
            repeat ($urandom % 2) @(posedge clk);
         end
      end
      repeat (4) @(posedge clk);
   endtask

   task automatic read_rx;
      u_host.set_page(CSUB_PG_RX);
      for (int ch = 0; ch < 2; ch++) begin
         for (int b = 0; b < 24; b++) begin
            u_host.access(1'b0, 7'(2*b+ch), 8'h00, q);
            check("rx status byte", cs[ch][b], q);
            u_host.access(1'b0, 7'(CSUB_UD_BASE+2*b+ch), 8'h00, q);
            check("rx user byte", ud[ch][b], q);
         end
      end
   endtask

   task automatic fetch(input logic u, input int ch, input int idx);
      int n;
      n = 0;
      @(posedge clk);
      tx_req      <= 1'b1;
      tx_ud       <= u;
      tx_chan     <= 1'(ch);
      tx_byte_idx <= 5'(idx);
      @(posedge clk);
      tx_req      <= 1'b0;
      tx_byte_idx <= ~5'(idx);
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (tx_ack !== 1'b1 && n < 8);
      q = (n < 8) ? tx_byte : 8'hxx;
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      print_verdict();
   end

   initial begin
      seed = $urandom(3);
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      check("page after reset", 8'h00, {6'h00, page});
      for (int p = 3; p >= 0; p--) begin
         u_host.set_page(2'(p));
         u_host.access(1'b0, CSUB_PAGE_ADDR, 8'h00, q);
         check("page readback", 8'(p), q);
         check("page output", 8'(p), {6'h00, page});
      end
      u_host.access(1'b0, 7'h00, 8'h00, q);
      check("control page buffer read", 8'h00, q);
      gen_block(1'b0);
      send_block(192, 1'b0);
      send_block(40, 1'b1);
      read_rx();
      check("consumer mode", 8'h00, {7'h00, rx_pro_mode});
      check("consumer crc error", 8'h00, {6'h00, rx_crc_err});
      gen_block(1'b1);
      cs[0][23] = crc_ref(0);
      cs[1][23] = ~crc_ref(1);
      send_block(192, 1'b0);
      read_rx();
      check("pro mode", 8'h01, {7'h00, rx_pro_mode});
      check("crc error", 8'h02, {6'h00, rx_crc_err});
      a = $urandom % 48;
      u_host.access(1'b1, 7'(a), ~cs[a%2][a/2], q);
      u_host.access(1'b0, 7'(a), 8'h00, q);
      check("rx read only", cs[a%2][a/2], q);
      u_host.access(1'b0, 7'h30, 8'h00, q);
      check("gap read", 8'h00, q);
      gen_block(1'b0);
      cs[0][0][7] = 1'b1;
      u_host.set_page(CSUB_PG_TX);
      for (int i = 0; i < 48; i++) begin
         if (i != 46) begin
            u_host.access(1'b1, 7'(i), cs[i%2][i/2], q);
         end
         u_host.access(1'b1, 7'(CSUB_UD_BASE+i), ud[i%2][i/2], q);
      end
      for (int b = 0; b < 24; b++) begin
         for (int ch = 0; ch < 2; ch++) begin
            fetch(1'b0, ch, b);
            check("tx status", (ch == 0 && b == 23) ? crc_ref(0)
                  : cs[ch][b], q);
            a = $urandom % 24;
            fetch(1'b1, ch, a);
            check("tx user", ud[ch][a], q);
         end
      end
      fetch(1'b0, 0, 24);
      check("tx index past end", 8'h00, q);
      check("host answer", 8'h00, {7'h00, to});
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      check("mode after mid reset", 8'h00, {7'h00, rx_pro_mode});
      check("crc error after mid reset", 8'h00, {6'h00, rx_crc_err});
      check("page after mid reset", 8'h00, {6'h00, page});
      print_verdict();
   end
endmodule
